//--- hw/core_exec_pkg.sv
// package: encodings, register map and flag layout for the exec block
//
// Behaviour
// - return-with-literal loads the accumulator with the 8-bit literal.
// - return-with-literal pops the stack into the pc; takes two cycles.
// - call then add of accumulator to pc low byte selects a table entry.
// - rotate-left moves bit 7 to carry, old carry to bit 0; one cycle.
// - rotate-right moves bit 0 to carry, old carry to bit 7; one cycle.
// - destination bit 0 writes the accumulator, 1 writes the file register.
// - rotates change carry only; zero and half-carry keep their values.
// - standby stops the oscillator, enters sleep after one cycle, sets expiry and clears power-down.
// - subtract computes file minus accumulator, two's complement, one cycle.
// - subtract sets carry on no borrow, zero on zero result, half-carry.
package core_exec_pkg;
  // ---------------------------------------------------------------
  // opcodes, 14-bit instruction word
  // ---------------------------------------------------------------
  localparam logic [5:0]  OP_ROTL_HI = 6'h0D;   // 00 1101 dfff ffff
  localparam logic [5:0]  OP_ROTR_HI = 6'h0C;   // 00 1100 dfff ffff
  localparam logic [5:0]  OP_SUB_HI  = 6'h02;   // 00 0010 dfff ffff
  localparam logic [5:0]  OP_ADD_HI  = 6'h07;   // 00 0111 dfff ffff
  localparam logic [5:0]  OP_RETL_HI = 6'h18;   // 01 1000 kkkk kkkk
  localparam logic [1:0]  OP_CALL_HI = 2'h2;    // 10 kkkk kkkk kkkk
  localparam logic [13:0] OP_SLEEP   = 14'h0003;
  localparam logic [6:0]  PC_LOW_ADDR = 7'h02;  // file address of pc low
  localparam logic [1:0]  CYC_ONE    = 2'h1;
  localparam logic [1:0]  CYC_TWO    = 2'h2;
  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_INSTR  = 8'h00;
  localparam logic [7:0] REG_ACC    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PC     = 8'h0C;
  localparam logic [7:0] REG_FADDR  = 8'h10;
  localparam logic [7:0] REG_FDATA  = 8'h14;
  localparam logic [7:0] REG_CTRL   = 8'h18;
  localparam logic [7:0] REG_CYCLES = 8'h1C;
  localparam int         CTRL_WAKE  = 0;
  localparam int         INSTR_BUSY = 31;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;
  // ---------------------------------------------------------------
  // status flags: carry, half-carry, zero, power-down, expiry from bit 0
  // ---------------------------------------------------------------
  typedef struct packed {
    logic watchdog_expiry_flag;
    logic powerdown_flag;
    logic z;
    logic half_carry_flag;
    logic c;
  } status_t;
  localparam status_t STATUS_RST = 5'h18;  // expiry and power-down set
  // ---------------------------------------------------------------
  // exec states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_FETCH = 4'b0010,
    S_EXEC  = 4'b0100,
    S_WAIT  = 4'b1000
  } state_t;
endpackage : core_exec_pkg

//--- hw/file_ram.sv
// file register memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module file_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // clock
  input  wire logic          aclk,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output var  logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  // storage write
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read data registered; old data on a same-address write
  always_ff @(posedge aclk) begin
    rdata <= mem[raddr];
  end
endmodule : file_ram
`default_nettype wire

//--- hw/core_exec.sv
// exec block: return-literal, rotates, standby, subtract, with axi4-lite
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module core_exec #(
  parameter int PC_W     = 10,
  parameter int STACK_D  = 8,
  parameter int CYC_CLKS = 4
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // core status
  output var  logic        busy,
  output var  logic        sleep_mode,
  output var  logic        osc_run,
  output var  logic        wdt_clear
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  core_exec_pkg::state_t  st_reg;
  core_exec_pkg::status_t stat_reg;
  logic [7:0]      acc_reg;
  logic [PC_W-1:0] pc_reg;
  logic [13:0]     ir_reg;
  logic [6:0]      faddr_reg;
  logic [7:0]      cycles_reg;
  logic [1:0]      need_reg;
  logic [1:0]      done_reg;
  logic [$clog2(CYC_CLKS)-1:0] div_reg;
  logic            cyc_en;
  logic [PC_W-1:0] stack_reg [STACK_D];
  logic [$clog2(STACK_D)-1:0] sp_reg;

  // axi holding
  logic        aw_full_reg, w_full_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        do_wr;
  logic        wr_ok;
  logic        rd_pend_reg;
  logic [7:0]  ar_addr_reg;

  // ---------------------------------------------------------------
  // decode of the latched instruction
  // ---------------------------------------------------------------
  logic       rotate_left_op, rotate_right_op, is_sub, is_add;
  logic       is_retl, is_call, is_sleep;
  logic       dest_f;
  logic [6:0] f_addr;
  logic [PC_W-1:0] pc_inc;
  assign rotate_left_op  = (ir_reg[13:8] == core_exec_pkg::OP_ROTL_HI);
  assign rotate_right_op = (ir_reg[13:8] == core_exec_pkg::OP_ROTR_HI);
  assign is_sub   = (ir_reg[13:8] == core_exec_pkg::OP_SUB_HI);
  assign is_add   = (ir_reg[13:8] == core_exec_pkg::OP_ADD_HI);
  assign is_retl  = (ir_reg[13:8] == core_exec_pkg::OP_RETL_HI);
  assign is_call  = (ir_reg[13:12] == core_exec_pkg::OP_CALL_HI);
  assign is_sleep = (ir_reg == core_exec_pkg::OP_SLEEP);
  assign dest_f   = ir_reg[7];
  assign f_addr   = ir_reg[6:0];
  assign pc_inc   = pc_reg + PC_W'(1);

  // ---------------------------------------------------------------
  // file memory; exec owns the port while busy, software when idle
  // ---------------------------------------------------------------
  logic       mem_we;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [6:0] mem_raddr;
  logic       ex_fwrite;
  logic [7:0] res;
  assign mem_raddr = (st_reg == core_exec_pkg::S_IDLE) ? faddr_reg : f_addr;

  file_ram #(.AW(7), .DW(8)) u_ram (
    .aclk  (aclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // operand: pc low reads as the address of the next instruction
  logic [7:0] fv;
  assign fv = (f_addr == core_exec_pkg::PC_LOW_ADDR) ? pc_inc[7:0]
                                                     : mem_rdata;

  // ---------------------------------------------------------------
  // arithmetic
  // ---------------------------------------------------------------
  logic [8:0] diff9, sum9;
  logic [4:0] sum_lo;
  assign diff9  = {1'b0, fv} - {1'b0, acc_reg};
  assign sum9   = {1'b0, fv} + {1'b0, acc_reg};
  assign sum_lo = {1'b0, fv[3:0]} + {1'b0, acc_reg[3:0]};

  // result mux and new flags
  core_exec_pkg::status_t stat_new;
  always_comb begin
    res      = fv;
    stat_new = stat_reg;
    if (rotate_left_op) begin
      res        = {fv[6:0], stat_reg.c};
      stat_new.c = fv[7];
    end else if (rotate_right_op) begin
      res        = {stat_reg.c, fv[7:1]};
      stat_new.c = fv[0];
    end else if (is_sub) begin
      res         = diff9[7:0];
      stat_new.c  = ~diff9[8];
      stat_new.half_carry_flag = (fv[3:0] >= acc_reg[3:0]);
      stat_new.z  = (diff9[7:0] == 8'h00);
    end else if (is_add) begin
      res         = sum9[7:0];
      stat_new.c  = sum9[8];
      stat_new.half_carry_flag = sum_lo[4];
      stat_new.z  = (sum9[7:0] == 8'h00);
    end
  end

  logic alu_op;
  assign alu_op    = rotate_left_op | rotate_right_op | is_sub | is_add;
  assign ex_fwrite = (st_reg == core_exec_pkg::S_EXEC) && alu_op && dest_f
                     && (f_addr != core_exec_pkg::PC_LOW_ADDR);

  // memory write port mux
  always_comb begin
    mem_we    = ex_fwrite;
    mem_waddr = f_addr;
    mem_wdata = res;
    if (st_reg == core_exec_pkg::S_IDLE) begin
      mem_we    = wr_ok && (aw_addr_reg == core_exec_pkg::REG_FDATA)
                  && w_strb_reg[0];
      mem_waddr = faddr_reg;
      mem_wdata = w_data_reg[7:0];
    end
  end

  // ---------------------------------------------------------------
  // instruction cycle divider
  // ---------------------------------------------------------------
  // one enable pulse per instruction cycle; free running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= '0;
    end else if (div_reg == ($clog2(CYC_CLKS))'(CYC_CLKS - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
  assign cyc_en = (div_reg == '0);

  // ---------------------------------------------------------------
  // axi write: address and data taken in either order
  // ---------------------------------------------------------------
  logic wr_mapped;
  assign do_wr = aw_full_reg && w_full_reg && !s_axi_bvalid;
  always_comb begin
    case (aw_addr_reg)
      core_exec_pkg::REG_INSTR, core_exec_pkg::REG_ACC,
      core_exec_pkg::REG_STATUS, core_exec_pkg::REG_PC,
      core_exec_pkg::REG_FADDR, core_exec_pkg::REG_FDATA,
      core_exec_pkg::REG_CTRL: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end
  // all writes are refused while busy, and all but the wake bit write while asleep
  logic wr_wake;
  assign wr_wake = do_wr && (aw_addr_reg == core_exec_pkg::REG_CTRL);
  assign wr_ok   = do_wr && wr_mapped && !sleep_mode
                   && (st_reg == core_exec_pkg::S_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= core_exec_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_full_reg && !s_axi_awready;
      s_axi_wready  <= !w_full_reg && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_ok || (wr_wake && sleep_mode))
                        ? core_exec_pkg::RESP_OKAY : core_exec_pkg::RESP_SLV;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // exec sequencer
  // ---------------------------------------------------------------
  logic issue;
  assign issue = wr_ok && (aw_addr_reg == core_exec_pkg::REG_INSTR);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg     <= core_exec_pkg::S_IDLE;
      ir_reg     <= 14'h0000;
      need_reg   <= core_exec_pkg::CYC_ONE;
      done_reg   <= 2'h0;
      cycles_reg <= 8'h00;
      busy       <= 1'b0;
    end else begin
      case (st_reg)
        core_exec_pkg::S_IDLE: if (issue) begin
          ir_reg <= w_data_reg[13:0];
          st_reg <= core_exec_pkg::S_FETCH;
          busy   <= 1'b1;
        end
        core_exec_pkg::S_FETCH: st_reg <= core_exec_pkg::S_EXEC;
        core_exec_pkg::S_EXEC: begin
          need_reg <= (is_retl || is_call) ? core_exec_pkg::CYC_TWO
                                           : core_exec_pkg::CYC_ONE;
          done_reg <= 2'h0;
          st_reg   <= core_exec_pkg::S_WAIT;
        end
        core_exec_pkg::S_WAIT: if (cyc_en) begin
          done_reg <= done_reg + 2'h1;
          if (done_reg + 2'h1 == need_reg) begin
            cycles_reg <= {6'h00, need_reg};
            st_reg     <= core_exec_pkg::S_IDLE;
            busy       <= 1'b0;
          end
        end
        default: st_reg <= core_exec_pkg::S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // accumulator, pc, stack and flags
  // ---------------------------------------------------------------
  logic ex;
  assign ex = (st_reg == core_exec_pkg::S_EXEC);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg   <= 8'h00;
      pc_reg    <= '0;
      sp_reg    <= '0;
      faddr_reg <= 7'h00;
      stat_reg  <= core_exec_pkg::STATUS_RST;
    end else if (ex) begin
      stat_reg <= stat_new;
      pc_reg   <= pc_inc;
      if (alu_op && !dest_f) begin
        acc_reg <= res;
      end
      if (alu_op && dest_f && f_addr == core_exec_pkg::PC_LOW_ADDR) begin
        pc_reg <= {pc_inc[PC_W-1:8], res};
      end
      if (is_call) begin
        stack_reg[sp_reg] <= pc_inc;
        sp_reg            <= sp_reg + 1'b1;
        pc_reg            <= ir_reg[PC_W-1:0];
      end
      if (is_retl) begin
        acc_reg <= ir_reg[7:0];
        pc_reg  <= stack_reg[sp_reg - 1'b1];
        sp_reg  <= sp_reg - 1'b1;
      end
      if (is_sleep) begin
        stat_reg.powerdown_flag       <= 1'b0;
        stat_reg.watchdog_expiry_flag <= 1'b1;
      end
    end else if (wr_ok) begin
      case (aw_addr_reg)
        core_exec_pkg::REG_ACC:    acc_reg   <= w_data_reg[7:0];
        core_exec_pkg::REG_PC:     pc_reg    <= w_data_reg[PC_W-1:0];
        core_exec_pkg::REG_FADDR:  faddr_reg <= w_data_reg[6:0];
        core_exec_pkg::REG_STATUS: stat_reg  <= w_data_reg[4:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sleep, oscillator and watchdog clear
  // ---------------------------------------------------------------
  // sleep takes effect as the standby's single cycle closes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_mode <= 1'b0;
      osc_run    <= 1'b1;
      wdt_clear  <= 1'b0;
    end else begin
      wdt_clear <= ex && is_sleep;
      if (st_reg == core_exec_pkg::S_WAIT && cyc_en && is_sleep) begin
        sleep_mode <= 1'b1;
        osc_run    <= 1'b0;
      end else if (wr_wake && sleep_mode
                   && w_data_reg[core_exec_pkg::CTRL_WAKE]) begin
        sleep_mode <= 1'b0;
        osc_run    <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi read: answer two cycles after the address is taken
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= core_exec_pkg::RESP_OKAY;
      rd_pend_reg   <= 1'b0;
      ar_addr_reg   <= 8'h00;
    end else begin
      s_axi_arready <= !rd_pend_reg && !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend_reg   <= 1'b1;
        ar_addr_reg   <= s_axi_araddr;
        s_axi_arready <= 1'b0;
      end else if (rd_pend_reg) begin
        rd_pend_reg  <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= core_exec_pkg::RESP_OKAY;
        case (ar_addr_reg)
          core_exec_pkg::REG_INSTR:
            s_axi_rdata <= {busy, 17'h0_0000, ir_reg};
          core_exec_pkg::REG_ACC:    s_axi_rdata <= {24'h00_0000, acc_reg};
          core_exec_pkg::REG_STATUS:
            s_axi_rdata <= {26'h000_0000, sleep_mode, stat_reg};
          core_exec_pkg::REG_PC:
            s_axi_rdata <= {{(32-PC_W){1'b0}}, pc_reg};
          core_exec_pkg::REG_FADDR:  s_axi_rdata <= {25'h000_0000, faddr_reg};
          core_exec_pkg::REG_FDATA:  s_axi_rdata <= {24'h00_0000, mem_rdata};
          core_exec_pkg::REG_CTRL:   s_axi_rdata <= 32'h0000_0000;
          core_exec_pkg::REG_CYCLES: s_axi_rdata <= {24'h00_0000, cycles_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= core_exec_pkg::RESP_SLV;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : core_exec
`default_nettype wire

//--- test/core_exec_props.sv
// checker: bus handshakes, busy span and standby behaviour at the ports
`timescale 1ns/10ps
`default_nettype none
module core_exec_props #(
  parameter int CYC_CLKS = 4
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // core status
  input wire logic        busy,
  input wire logic        sleep_mode,
  input wire logic        osc_run,
  input wire logic        wdt_clear
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------
  // named steps
  // ----------------------------------------------------------
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_answer;
    ##2 s_axi_rvalid;
  endsequence
  // bounds sized for CYC_CLKS up to 8 (two-cycle worst case 18 clocks)
  sequence busy_span;
    busy [*2] ##[1:24] !busy;
  endsequence
  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  read_latency_a: assert property (rd_taken |-> rd_answer)
    else $error("read answer not two cycles after address");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed early");
  bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after being taken");
  busy_bound_a: assert property ($rose(busy) |-> busy_span)
    else $error("instruction busy span out of range");
  osc_sleep_a: assert property (osc_run != sleep_mode)
    else $error("oscillator running while asleep or stopped awake");
  wdt_pulse_a: assert property (wdt_clear |=> !wdt_clear)
    else $error("watchdog clear wider than one cycle");
  sleep_entry_a: assert property (wdt_clear |-> ##[0:20] sleep_mode)
    else $error("standby did not reach sleep");
  sleep_quiet_a: assert property (sleep_mode && $past(sleep_mode) |-> !busy)
    else $error("instruction running while asleep");
endmodule : core_exec_props
`default_nettype wire

//--- test/core_exec_tb.sv
// self-checking bench for the exec block over its register bus
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    tests_run++; \
    if ((got) !== (ex)) begin \
      err_count++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module core_exec_tb;
  typedef struct packed {
    logic [13:0]           ins;
    logic [7:0]            acc;
    logic [7:0]            f;
    core_exec_pkg::status_t st;
    logic [7:0]            eacc;
    logic [7:0]            ef;
    core_exec_pkg::status_t est;
    logic [1:0]            cyc;
  } row_t;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, dat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        busy, sleep_mode, osc_run, wdt_clear;
  int          err_count = 0;
  int          tests_run = 0;
  int          wdt_seen  = 0;
  // slow instruction cycle keeps busy open long enough to collide with
  core_exec #(.CYC_CLKS(8)) u_dut (.*);
  // ----------------------------------------------------------
  // clock, pulse count, watchdog
  // ----------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) if (wdt_clear === 1'b1) wdt_seen <= wdt_seen + 1;
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    wrap_up();
  end
  // ----------------------------------------------------------
  // bus tasks: each starts one edge on so no signal is driven twice
  // ----------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 64) err_count++;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        dat = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 64) err_count++;
  endtask : rd
  // poll the busy bit rather than assume a span, phase varies
  task automatic idle();
    int n;
    for (n = 0; n < 40; n++) begin
      rd(core_exec_pkg::REG_INSTR);
      if (dat[31] === 1'b0) break;
    end
    if (n == 40) err_count++;
  endtask : idle
  task automatic run(input logic [13:0] ins);
    wr(core_exec_pkg::REG_INSTR, 32'(ins));
    idle();
  endtask : run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin : main
    row_t rows [9];
    int   i;
    rows = '{
      '{14'h0d20, 8'h55, 8'he6, 5'h1e, 8'hcc, 8'he6, 5'h1f, 2'h1},
      '{14'h0da0, 8'h55, 8'h80, 5'h19, 8'h55, 8'h01, 5'h19, 2'h1},
      '{14'h0c20, 8'h55, 8'he6, 5'h1e, 8'h73, 8'he6, 5'h1e, 2'h1},
      '{14'h0ca0, 8'h55, 8'h01, 5'h19, 8'h55, 8'h80, 5'h19, 2'h1},
      '{14'h02a0, 8'h02, 8'h03, 5'h18, 8'h02, 8'h01, 5'h1b, 2'h1},
      '{14'h02a0, 8'h02, 8'h02, 5'h18, 8'h02, 8'h00, 5'h1f, 2'h1},
      '{14'h0220, 8'h02, 8'h01, 5'h1f, 8'hff, 8'h01, 5'h18, 2'h1},
      '{14'h0220, 8'h01, 8'h10, 5'h18, 8'h0f, 8'h10, 5'h19, 2'h1},
      '{14'h18a5, 8'h02, 8'h33, 5'h07, 8'ha5, 8'h33, 5'h07, 2'h2}};
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(core_exec_pkg::REG_STATUS);
    `CHK("status after reset", 6'h18, dat[5:0])
    rd(core_exec_pkg::REG_ACC);
    `CHK("acc after reset", 8'h00, dat[7:0])
    // table rows: rotates, subtracts, literal return, both destinations
    for (i = 0; i < 9; i++) begin
      wr(core_exec_pkg::REG_ACC, 32'(rows[i].acc));
      wr(core_exec_pkg::REG_STATUS, 32'(rows[i].st));
      wr(core_exec_pkg::REG_FADDR, 32'h0000_0020);
      wr(core_exec_pkg::REG_FDATA, 32'(rows[i].f));
      run(rows[i].ins);
      rd(core_exec_pkg::REG_ACC);
      `CHK("acc", rows[i].eacc, dat[7:0])
      rd(core_exec_pkg::REG_STATUS);
      `CHK("flags", rows[i].est, dat[4:0])
      rd(core_exec_pkg::REG_FDATA);
      `CHK("file", rows[i].ef, dat[7:0])
      rd(core_exec_pkg::REG_CYCLES);
      `CHK("cycles", rows[i].cyc, dat[1:0])
    end
    // table lookup: call, add acc to pc low, literal return
    wr(core_exec_pkg::REG_PC, 32'h0000_0010);
    wr(core_exec_pkg::REG_ACC, 32'h0000_0002);
    run(14'h2100);
    run(14'h0782);
    rd(core_exec_pkg::REG_PC);
    `CHK("pc jump", 10'h103, dat[9:0])
    run(14'h183c);
    rd(core_exec_pkg::REG_PC);
    `CHK("pc return", 10'h011, dat[9:0])
    rd(core_exec_pkg::REG_ACC);
    `CHK("literal", 8'h3c, dat[7:0])
    // collide with a two-cycle instruction still running
    wr(core_exec_pkg::REG_INSTR, 32'h0000_18c3);
    wr(core_exec_pkg::REG_ACC, 32'h0000_0099);
    `CHK("busy write", 2'h2, rsp)
    idle();
    rd(core_exec_pkg::REG_ACC);
    `CHK("literal kept", 8'hc3, dat[7:0])
    // unmapped offset
    wr(8'h40, 32'h0000_0001);
    `CHK("unmapped write", 2'h2, rsp)
    rd(8'h40);
    `CHK("unmapped read", 2'h2, rsp)
    // standby, refused write while asleep, then wake
    wr(core_exec_pkg::REG_STATUS, 32'h0000_0007);
    run(14'h0003);
    `CHK("asleep", 1'b1, sleep_mode)
    `CHK("osc stopped", 1'b0, osc_run)
    rd(core_exec_pkg::REG_STATUS);
    `CHK("sleep flags", 6'h37, dat[5:0])
    `CHK("wdt pulses", 1, wdt_seen)
    wr(core_exec_pkg::REG_ACC, 32'h0000_0011);
    `CHK("sleep write", 2'h2, rsp)
    wr(core_exec_pkg::REG_CTRL, 32'h0000_0001);
    `CHK("wake write", 2'h0, rsp)
    repeat (4) @(posedge aclk);
    `CHK("awake", 1'b0, sleep_mode)
    `CHK("osc running", 1'b1, osc_run)
    // second reset, with the core idle after wake, must bring acc and status back to their start values
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(core_exec_pkg::REG_ACC);
    `CHK("acc after second reset", 8'h00, dat[7:0])
    rd(core_exec_pkg::REG_STATUS);
    `CHK("status after second reset", 6'h18, dat[5:0])
    wrap_up();
  end
endmodule : core_exec_tb
bind core_exec core_exec_props #(.CYC_CLKS(8)) u_props (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .busy, .sleep_mode, .osc_run, .wdt_clear);
`default_nettype wire
